// ===== hdl/spb_pkg.sv
package spb_pkg;

  // Register offsets (7-bit address space)
  localparam logic [6:0] SPB_OFF_CHIP_RESET = 7'h3A;
  localparam logic [6:0] SPB_OFF_SHUTDOWN = 7'h3B;
  localparam logic [6:0] SPB_OFF_LIFT_LIMIT = 7'h3D;
  localparam logic [6:0] SPB_OFF_INV_REV = 7'h3E;
  localparam logic [6:0] SPB_OFF_INV_PART = 7'h3F;
  localparam logic [6:0] SPB_OFF_BURST = 7'h42;

  // Pin levels while idle: ncs_n high, sclk high, mosi low
  localparam logic [2:0] SPB_PIN_IDLE = 3'h6;

  // Command codes
  localparam logic [7:0] SPB_CODE_CHIP_RESET = 8'h5A;
  localparam logic [7:0] SPB_CODE_SHUTDOWN = 8'hE7;

  // Lift limit: reset value and threshold field position
  localparam logic [7:0] SPB_LIFT_RST = 8'h56;
  localparam int SPB_LIFT_LSB = 1;
  // Threshold scaling: shutter by 32, saturation by 2 (as shift counts)
  localparam int SPB_LIFT_SHIFT = 5;
  localparam int SPB_SAT_SHIFT = 1;

  // Burst: number of bytes, and byte after which motion is cleared
  localparam logic [3:0] SPB_BURST_LEN = 4'h8;
  localparam logic [3:0] SPB_BURST_CLR = 4'h3;

  // Serial port state
  typedef enum logic [1:0] {
    SPB_IDLE = 2'b00,
    SPB_ADDR = 2'b01,
    SPB_WDATA = 2'b10,
    SPB_RDATA = 2'b11
  } spb_state_e;

  // Motion data presented by the navigation core
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] x_move_low;
    logic [7:0] y_move_low;
    logic [7:0] xy_move_high;
    logic [7:0] surface_quality;
    logic [7:0] exposure_upper;
    logic [7:0] exposure_lower;
    logic [7:0] peak_pixel;
    logic [7:0] saturated_count;
    logic [7:0] saturation_thr;
  } spb_motion_s;

  // State of the register bank, apart from the reset release synchroniser
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sclk_prev;
    spb_state_e st;
    logic [2:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [6:0] addr;
    logic [3:0] burst_idx;
    logic [6:0] lift;
    logic shut;
    logic rst_pulse;
    logic mclr;
    logic supp;
    logic miso;
    logic miso_oe;
  } spb_regs_s;

endpackage

// ===== hdl/spb_regbank.sv
`timescale 1ns/1ns
module spb_regbank
  import spb_pkg::*;
#(
  parameter logic [7:0] REV_CODE = 8'h21,  // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h5C  // Arbitrary value
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ncs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire spb_motion_s motion,
  output logic motion_clear,
  output logic motion_suppress,
  output logic shutdown,
  output logic chip_reset,
  output logic [6:0] lift_limit
);

  // Reset release synchroniser
  logic [1:0] rst_sync_q;
  logic rst_n;
  // Registered state and its next value
  spb_regs_s q, d;
  // Write and load events, for the checks below
  logic wr_fire;
  logic [7:0] wr_data;
  logic ld_fire;
  logic [6:0] ld_addr;
  logic rise, fall;
  logic [7:0] rx_n;

  // Single-register read decode
  function automatic logic [7:0] read_byte(input logic [6:0] a,
                                           input spb_motion_s m,
                                           input logic [6:0] lift);
    case (a)
      SPB_OFF_LIFT_LIMIT: read_byte = {lift, 1'b0};
      SPB_OFF_INV_REV: read_byte = ~REV_CODE;
      SPB_OFF_INV_PART: read_byte = ~PART_CODE;
      SPB_OFF_BURST: read_byte = m.status;
      default: read_byte = 8'h00;
    endcase
  endfunction

  // Burst byte by position
  function automatic logic [7:0] burst_byte(input logic [3:0] i,
                                            input spb_motion_s m);
    case (i)
      4'h0: burst_byte = m.status;
      4'h1: burst_byte = m.x_move_low;
      4'h2: burst_byte = m.y_move_low;
      4'h3: burst_byte = m.xy_move_high;
      4'h4: burst_byte = m.surface_quality;
      4'h5: burst_byte = m.exposure_upper;
      4'h6: burst_byte = m.exposure_lower;
      4'h7: burst_byte = m.peak_pixel;
      default: burst_byte = 8'h00;
    endcase
  endfunction

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Next-state logic
  always_comb
  begin
    d = q;
    d.rst_pulse = 1'b0;
    d.mclr = 1'b0;
    wr_fire = 1'b0;
    wr_data = 8'h00;
    ld_fire = 1'b0;
    ld_addr = 7'h00;
    // Pins pass two flops first
    d.sync1 = {ncs_n, sclk, mosi};
    d.sync2 = q.sync1;
    d.sclk_prev = q.sync2[1];
    rise = q.sync2[1] & ~q.sclk_prev;
    fall = ~q.sync2[1] & q.sclk_prev;
    rx_n = {q.rx[6:0], q.sync2[0]};
    // Lift runaway test
    d.supp = ({motion.exposure_upper, motion.exposure_lower} >
              ({9'h000, q.lift} << SPB_LIFT_SHIFT)) &&
             ({1'b0, motion.saturated_count} >
              ({1'b0, motion.saturation_thr} << SPB_SAT_SHIFT));
    if (q.sync2[2])
    begin
      // Deselected: frame ends, pin released
      d.st = SPB_IDLE;
      d.bit_cnt = 3'h0;
      d.miso_oe = 1'b0;
    end
    else
    begin
      d.miso_oe = 1'b1;
      if (q.st == SPB_IDLE)
        d.st = SPB_ADDR;
      // Sample on rising edge
      if (rise && q.st != SPB_IDLE)
      begin
        d.rx = rx_n;
        d.bit_cnt = q.bit_cnt + 3'h1;
        if (q.bit_cnt == 3'h7)
        begin
          case (q.st)
            SPB_ADDR:
            begin
              d.addr = rx_n[6:0];
              if (rx_n[7])
                d.st = SPB_WDATA;
              else
              begin
                // Read: first byte ready for next falling edge
                d.st = SPB_RDATA;
                d.tx = read_byte(rx_n[6:0], motion, q.lift);
                ld_fire = 1'b1;
                ld_addr = rx_n[6:0];
                d.burst_idx = 4'h1;
              end
            end
            SPB_WDATA:
            begin
              wr_fire = 1'b1;
              wr_data = rx_n;
              d.st = SPB_ADDR;
              case (q.addr)
                SPB_OFF_CHIP_RESET:
                  if (rx_n == SPB_CODE_CHIP_RESET)
                  begin
                    d.rst_pulse = 1'b1;
                    d.lift = SPB_LIFT_RST[7:SPB_LIFT_LSB];
                    d.shut = 1'b0;
                  end
                SPB_OFF_SHUTDOWN:
                  if (rx_n == SPB_CODE_SHUTDOWN)
                    d.shut = 1'b1;
                SPB_OFF_LIFT_LIMIT:
                  d.lift = rx_n[7:SPB_LIFT_LSB];
                default:
                  d.shut = q.shut;
              endcase
            end
            SPB_RDATA:
            begin
              if (q.addr == SPB_OFF_BURST)
              begin
                // Burst continues until deselect
                d.tx = burst_byte(q.burst_idx, motion);
                if (q.burst_idx < SPB_BURST_LEN)
                  d.burst_idx = q.burst_idx + 4'h1;
                if (q.burst_idx == SPB_BURST_CLR)
                  d.mclr = 1'b1;
              end
              else
                d.st = SPB_ADDR;
            end
            default:
              d.st = SPB_IDLE;
          endcase
        end
      end
      // Shift out on falling edge
      if (fall)
      begin
        d.miso = q.tx[7];
        d.tx = {q.tx[6:0], 1'b0};
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= SPB_IDLE;
      // Synchronisers start at idle pin levels, so no false edge
      q.sync1 <= SPB_PIN_IDLE;
      q.sync2 <= SPB_PIN_IDLE;
      q.sclk_prev <= SPB_PIN_IDLE[1];
      q.lift <= SPB_LIFT_RST[7:SPB_LIFT_LSB];
    end
    else
      q <= d;
  end

  // Outputs straight from flops
  assign miso = q.miso;
  assign miso_oe = q.miso_oe;
  assign motion_clear = q.mclr;
  assign motion_suppress = q.supp;
  assign shutdown = q.shut;
  assign chip_reset = q.rst_pulse;
  assign lift_limit = q.lift;

  // Checks
  a_reset_cmd_fires:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_fire && q.addr == SPB_OFF_CHIP_RESET &&
      wr_data == SPB_CODE_CHIP_RESET |=> chip_reset)
    else $error("chip reset not issued");
  a_reset_restores_cfg:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      chip_reset |-> lift_limit == SPB_LIFT_RST[7:SPB_LIFT_LSB] &&
      !shutdown)
    else $error("defaults not restored");
  a_shutdown_enter:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_fire && q.addr == SPB_OFF_SHUTDOWN &&
      wr_data == SPB_CODE_SHUTDOWN |=> shutdown)
    else $error("shutdown not entered");
  a_shutdown_exit:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(shutdown) |-> chip_reset)
    else $error("shutdown left without reset");
  a_lift_write:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_fire && q.addr == SPB_OFF_LIFT_LIMIT |=>
      {lift_limit, 1'b0} == ($past(wr_data) & 8'hFE))
    else $error("lift limit not stored");
  a_lift_suppress:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      {motion.exposure_upper, motion.exposure_lower} >
      {4'h0, lift_limit, 5'h00} &&
      motion.saturated_count > {motion.saturation_thr[6:0], 1'b0} &&
      !motion.saturation_thr[7] |=> motion_suppress)
    else $error("motion not suppressed");
  a_inv_rev_load:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      ld_fire && ld_addr == SPB_OFF_INV_REV |=> q.tx == ~REV_CODE)
    else $error("inverted revision wrong");
  a_inv_part_load:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      ld_fire && ld_addr == SPB_OFF_INV_PART |=> q.tx == ~PART_CODE)
    else $error("inverted part code wrong");
  a_clear_in_burst:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      motion_clear |-> $past(q.addr) == SPB_OFF_BURST &&
      $past(q.burst_idx) == SPB_BURST_CLR)
    else $error("motion cleared outside burst");
  a_bad_code_ignored:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_fire && q.addr == SPB_OFF_CHIP_RESET &&
      wr_data != SPB_CODE_CHIP_RESET |=> !chip_reset && $stable(lift_limit))
    else $error("bad reset code acted on");
  a_bad_shut_ignored:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_fire && q.addr == SPB_OFF_SHUTDOWN &&
      wr_data != SPB_CODE_SHUTDOWN |=> $stable(shutdown))
    else $error("bad shutdown code acted on");

endmodule

// ===== bench/spb_mcu.sv
`timescale 1ns/1ns
// Controller model on the four-wire port: sclk idles high
module spb_mcu
(
  input wire logic ref_clk,
  input wire logic miso,
  output logic ncs_n,
  output logic sclk,
  output logic mosi
);
  localparam int HALF = 10; // Half sclk period in clock cycles

  // Idle levels at time zero
  initial
  begin
    ncs_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
  end

  // Let n clock edges pass
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Select, leaving room for the pin synchroniser
  task automatic sel();
    @(posedge ref_clk);
    ncs_n <= 1'b0;
    idle(6);
  endtask

  // Release; data line stops showing the last bit
  task automatic desel();
    idle(HALF);
    ncs_n <= 1'b1;
    mosi <= ~mosi;
    idle(6);
  endtask

  // One byte each way, MSB first, shift falling, sample rising
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge ref_clk);
      sclk <= 1'b0;
      mosi <= tx[i];
      idle(HALF);
      sclk <= 1'b1;
      rx[i] = miso;
      idle(HALF - 1);
    end
  endtask
endmodule

// ===== bench/test_spb_regbank.sv
`timescale 1ns/1ns
// Self-checking bench for the register bank
module test_spb_regbank
  import spb_pkg::*;
;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary value
  localparam logic [7:0] PART = 8'h96; // Arbitrary value
  logic ref_clk = 1'b0; // 100 MHz clock
  logic reset_n = 1'b0; // Active-low reset
  logic ncs_n, sclk, mosi, miso, miso_oe;
  logic motion_clear, motion_suppress, shutdown, chip_reset;
  logic [6:0] lift_limit;
  logic miso_line; // Data line as the controller sees it
  // Released line no longer shows the last bit
  assign miso_line = miso_oe ? miso : ~miso;
  spb_motion_s motion = '0; // Core motion data
  int failures = 0;
  int n_tests = 0;
  int n_rst = 0; // Chip reset pulses seen
  int n_clr = 0; // Motion clear pulses seen
  logic [7:0] d;

  always #5 ref_clk = ~ref_clk;

  spb_regbank #(.REV_CODE(REV), .PART_CODE(PART)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .ncs_n(ncs_n), .sclk(sclk),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .motion(motion),
    .motion_clear(motion_clear), .motion_suppress(motion_suppress),
    .shutdown(shutdown), .chip_reset(chip_reset), .lift_limit(lift_limit));

  spb_mcu mcu_u (.ref_clk(ref_clk), .miso(miso_line), .ncs_n(ncs_n),
    .sclk(sclk), .mosi(mosi));

  // Count one-cycle pulses
  always @(posedge ref_clk)
  begin
    if (chip_reset === 1'b1) n_rst++;
    if (motion_clear === 1'b1) n_clr++;
  end

  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      failures++;
    end
  endtask

  // Register read and write frames
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    mcu_u.sel();
    check({7'h0, miso_oe}, 8'h01);
    mcu_u.xfer({1'b0, a}, v);
    mcu_u.xfer(8'h00, v);
    mcu_u.desel();
    check({7'h0, miso_oe}, 8'h00);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    mcu_u.sel();
    mcu_u.xfer({1'b1, a}, d);
    mcu_u.xfer(v, d);
    mcu_u.desel();
  endtask

  // Inverted identity codes and an unmapped place
  task automatic t_ident();
    rd(SPB_OFF_INV_REV, d);
    check(d, ~REV);
    rd(SPB_OFF_INV_PART, d);
    check(d, ~PART);
    rd(7'h3C, d);
    check(d, 8'h00);
    $display("test ident done");
  endtask

  // Lift limit field and a wrong shutdown code
  task automatic t_lift();
    check({1'b0, lift_limit}, 8'h2B);
    wr(SPB_OFF_LIFT_LIMIT, 8'hA5);
    check({1'b0, lift_limit}, 8'h52);
    rd(SPB_OFF_LIFT_LIMIT, d);
    check(d, 8'hA4);
    wr(SPB_OFF_SHUTDOWN, 8'hE6);
    check({7'h0, shutdown}, 8'h00);
    $display("test lift done");
  endtask

  // Shutdown, wrong reset code, then chip reset
  task automatic t_shut();
    wr(SPB_OFF_SHUTDOWN, 8'hE7);
    check({7'h0, shutdown}, 8'h01);
    wr(SPB_OFF_CHIP_RESET, 8'h5B);
    check({7'h0, shutdown}, 8'h01);
    check(8'(n_rst), 8'h00);
    wr(SPB_OFF_CHIP_RESET, 8'h5A);
    check(8'(n_rst), 8'h01);
    check({7'h0, shutdown}, 8'h00);
    check({1'b0, lift_limit}, 8'h2B);
    $display("test shutdown done");
  endtask

  // Suppress only when both limits are exceeded
  task automatic t_supp();
    motion.exposure_upper <= 8'h05;
    motion.exposure_lower <= 8'h61;
    motion.saturated_count <= 8'h21;
    motion.saturation_thr <= 8'h10;
    mcu_u.idle(4);
    check({7'h0, motion_suppress}, 8'h01);
    motion.exposure_lower <= 8'h60;
    mcu_u.idle(4);
    check({7'h0, motion_suppress}, 8'h00);
    motion.exposure_lower <= 8'h61;
    motion.saturated_count <= 8'h20;
    mcu_u.idle(4);
    check({7'h0, motion_suppress}, 8'h00);
    $display("test suppress done");
  endtask

  // Full burst, then one cut short
  task automatic t_burst();
    logic [7:0] e [8];
    int c0;
    e = '{8'h81, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'hDE};
    motion <= {e[0], e[1], e[2], e[3], e[4], e[5], e[6], e[7], 16'h0};
    c0 = n_clr;
    mcu_u.sel();
    mcu_u.xfer({1'b0, SPB_OFF_BURST}, d);
    for (int i = 0; i < 8; i++)
    begin
      mcu_u.xfer(8'h00, d);
      check(d, e[i]);
      if (i == 1) check(8'(n_clr - c0), 8'h00);
    end
    mcu_u.desel();
    check(8'(n_clr - c0), 8'h01);
    mcu_u.sel();
    mcu_u.xfer({1'b0, SPB_OFF_BURST}, d);
    mcu_u.xfer(8'h00, d);
    mcu_u.xfer(8'h00, d);
    check(d, e[1]);
    mcu_u.desel();
    check(8'(n_clr - c0), 8'h01);
    rd(SPB_OFF_INV_REV, d);
    check(d, ~REV);
    $display("test burst done");
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog on a hang
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    test_done();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    mcu_u.idle(6);
    t_ident();
    t_lift();
    t_shut();
    t_supp();
    t_burst();
    test_done();
  end
endmodule
